/* File: design/tccs_pkg.sv */
// package of constants for the timer clock source selection block
// Operation
// RL1: ext line 0 selector: code 0 pin0, 1 none, 2 chan1 wave A, 3 chan2 wave A.
// RL2: ext line 1 selector: code 0 pin1, 1 none, 2 chan0 wave A, 3 chan2 wave A.
// RL3: ext line 2 selector: code 0 pin2, 1 none, 2 chan0 wave A, 3 chan1 wave A.
// RL4: build parameters bit 9 reads one when bridge converts peripheral bus to high-speed bus.
// RL5: build parameters bit 8 reads one when up/down counting is built in.
// RL6: build parameters low field returns counter width in bits, read-only.
// RL7: revision register returns 12-bit version in low bits; reading has no side effect.
// RL8: variant field is reserved and steers nothing.
// RL9: each channel picks its own counting clock independently of the others.
// RL10: internal choice 1 is the 32 kHz oscillator clock.
// RL11: internal choices 2 to 5 are bus clock divided by 2, 8, 32, 128.
// RL12: each instance takes bus clock and divided clocks from its own bus domain.
// RL13: each instance has three external clock inputs, numbered 0 to 2.
// RL14: ext line selectors are 2-bit fields at 1:0, 3:2, 5:4 of mode register, reset zero.
// RL15: writes to build parameters and revision registers are ignored.
package tccs_pkg;
    localparam logic [7:0]  ADDR_BLOCK_MODE  = 8'hc4;
    localparam logic [7:0]  ADDR_CHAN_CLKSEL = 8'hc8;
    localparam logic [7:0]  ADDR_BUILD_PARAM = 8'hf8;
    localparam logic [7:0]  ADDR_MODULE_REV  = 8'hfc;
    localparam int          SEL0_LSB         = 0;
    localparam int          SEL1_LSB         = 2;
    localparam int          SEL2_LSB         = 4;
    localparam int          CHSEL_W          = 3;
    localparam int          BRIDGE_BIT       = 9;
    localparam int          UPDN_BIT         = 8;
    localparam int          REV_W            = 12;
    localparam int          VARIANT_LSB      = 16;
    localparam logic [1:0]  XSEL_PIN         = 2'h0;
    localparam logic [1:0]  XSEL_NONE        = 2'h1;
    localparam logic [1:0]  XSEL_WAVE_LO     = 2'h2;
    localparam logic [1:0]  XSEL_WAVE_HI     = 2'h3;
    localparam logic [2:0]  CLKSEL_RESET     = 3'h0;
    localparam logic [5:0]  MODE_RESET       = 6'h00;
    localparam logic [6:0]  DIV_MAX          = 7'h7f;
    // divided-clock tap bits: /2, /8, /32, /128 rise every 2^(n) cycles
    localparam logic [6:0]  DIV2_MASK        = 7'h01;
    localparam logic [6:0]  DIV8_MASK        = 7'h07;
    localparam logic [6:0]  DIV32_MASK       = 7'h1f;
    localparam logic [6:0]  DIV128_MASK      = 7'h7f;
    typedef enum logic [2:0] {
        CK_SLOW, CK_DIV2, CK_DIV8, CK_DIV32, CK_DIV128, CK_XC0, CK_XC1, CK_XC2
    } tccs_clk_e;
endpackage

/* File: design/tccs_sel_if.sv */
// interface carrying external line selectors and sources to the router
`timescale 1ns/10ps
interface tccs_sel_if;
    logic [1:0] sel [3];
    logic [2:0] pin;
    logic [2:0] wave;
    logic [2:0] line;
    modport ctrl  (output sel, output pin, output wave, input line);
    modport route (input sel, input pin, input wave, output line);
endinterface

/* File: design/tccs_top.sv */
// timer clock source selection: apb registers, prescaler, per-channel clock enables
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
module tccs_top #(
    parameter logic       BRIDGE_IS_PB_HSB = 1'b0,    // build option
    parameter logic       UPDOWN_PRESENT   = 1'b1,    // build option
    parameter logic [7:0] COUNTER_WIDTH    = 8'h10,   // counter bits
    parameter logic [11:0] REVISION        = 12'h123, // arbitrary value
    parameter logic [3:0] VARIANT          = 4'h0     // arbitrary value
) (
    input  wire logic        clock,        // bus clock of this instance
    input  wire logic        reset,        // async, active high
    input  wire logic        psel,         // apb select
    input  wire logic        penable,      // apb access phase
    input  wire logic        pwrite,       // apb direction
    input  wire logic [7:0]  paddr,        // apb byte address
    input  wire logic [31:0] pwdata,       // apb write data
    output logic      [31:0] prdata,       // apb read data
    output logic             pready,       // apb ready
    output logic             pslverr,      // apb error
    input  wire logic        slow_osc_clk, // 32 kHz oscillator, async
    input  wire logic [2:0]  ext_pin,      // dedicated external clock pins, async
    input  wire logic [2:0]  wave_out_a,   // channel waveform outputs A, same clock
    output logic      [2:0]  chan_clk_en,  // per-channel count enable pulse
    output logic      [2:0]  ext_line      // routed external clock lines
);
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [5:0]  mode;
        logic [8:0]  chsel;
        logic [6:0]  div;
        logic [2:0]  pin_m;
        logic [2:0]  pin_s;
        logic        osc_m;
        logic        osc_s;
        logic        osc_d;
        logic [2:0]  line_d;
        logic [2:0]  en;
        logic [2:0]  xl;
    } tccs_st_s;

    tccs_st_s st_r;
    tccs_st_s st_nxt;
    tccs_sel_if sif ();

    assign sif.sel[0] = st_r.mode[tccs_pkg::SEL0_LSB +: 2]; // RL14
    assign sif.sel[1] = st_r.mode[tccs_pkg::SEL1_LSB +: 2]; // RL14
    assign sif.sel[2] = st_r.mode[tccs_pkg::SEL2_LSB +: 2]; // RL14
    assign sif.pin    = st_r.pin_s; // RL13
    assign sif.wave   = wave_out_a;

    tccs_xroute u_route (
        .bus (sif.route)
    );

    function automatic logic [31:0] build_word();
        logic [31:0] w;
        w = 32'h0;
        w[7:0] = COUNTER_WIDTH; // RL6
        w[tccs_pkg::UPDN_BIT] = UPDOWN_PRESENT; // RL5
        w[tccs_pkg::BRIDGE_BIT] = BRIDGE_IS_PB_HSB; // RL4
        return w;
    endfunction

    // variant is shown but wired into nothing else
    function automatic logic [31:0] rev_word();
        logic [31:0] w;
        w = 32'h0;
        w[tccs_pkg::REV_W-1:0] = REVISION; // RL7
        w[tccs_pkg::VARIANT_LSB +: 4] = VARIANT; // RL8
        return w;
    endfunction

    // rising edge detect on a synchronised or routed level
    function automatic logic rise(input logic now, input logic was);
        rise = now & ~was;
    endfunction

    logic [7:0] tick;
    logic       setup;
    logic       wr;
    logic       rd;

    always_comb begin
        st_nxt = st_r;
        setup  = psel & ~penable;
        wr     = setup & pwrite;
        rd     = setup & ~pwrite;
        // two-stage synchronisers for pins and the slow oscillator
        st_nxt.pin_m  = ext_pin;
        st_nxt.pin_s  = st_r.pin_m;
        st_nxt.osc_m  = slow_osc_clk;
        st_nxt.osc_s  = st_r.osc_m;
        st_nxt.osc_d  = st_r.osc_s;
        st_nxt.line_d = sif.line;
        st_nxt.xl     = sif.line;
        // free-running prescaler, one counter serves all four divided rates
        st_nxt.div = st_r.div + 7'h01; // RL11 RL12
        tick[0] = rise(st_r.osc_s, st_r.osc_d); // RL10
        tick[1] = (st_r.div & tccs_pkg::DIV2_MASK) == tccs_pkg::DIV2_MASK; // RL11
        tick[2] = (st_r.div & tccs_pkg::DIV8_MASK) == tccs_pkg::DIV8_MASK; // RL11
        tick[3] = (st_r.div & tccs_pkg::DIV32_MASK) == tccs_pkg::DIV32_MASK; // RL11
        tick[4] = (st_r.div & tccs_pkg::DIV128_MASK) == tccs_pkg::DIV128_MASK; // RL11
        tick[5] = rise(sif.line[0], st_r.line_d[0]);
        tick[6] = rise(sif.line[1], st_r.line_d[1]);
        tick[7] = rise(sif.line[2], st_r.line_d[2]);
        for (int c = 0; c < 3; c++) begin
            st_nxt.en[c] = tick[st_r.chsel[c*tccs_pkg::CHSEL_W +: tccs_pkg::CHSEL_W]]; // RL9
        end
        // apb: answer in the access cycle; decode at setup
        st_nxt.pready  = setup;
        st_nxt.pslverr = 1'b0;
        st_nxt.prdata  = 32'h0;
        if (setup) begin
            case (paddr)
                tccs_pkg::ADDR_BLOCK_MODE: begin
                    if (wr) begin
                        st_nxt.mode = pwdata[5:0]; // RL14
                    end
                    st_nxt.prdata[5:0] = st_r.mode;
                end
                tccs_pkg::ADDR_CHAN_CLKSEL: begin
                    if (wr) begin
                        st_nxt.chsel = pwdata[8:0]; // RL9
                    end
                    st_nxt.prdata[8:0] = st_r.chsel;
                end
                tccs_pkg::ADDR_BUILD_PARAM: begin
                    st_nxt.prdata = rd ? build_word() : 32'h0; // RL15
                end
                tccs_pkg::ADDR_MODULE_REV: begin
                    st_nxt.prdata = rd ? rev_word() : 32'h0; // RL7 RL15
                end
                default: begin
                    st_nxt.pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_r <= '0;
            st_r.mode  <= tccs_pkg::MODE_RESET; // RL14
            st_r.chsel <= {3{tccs_pkg::CLKSEL_RESET}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata      = st_r.prdata;
    assign pready      = st_r.pready;
    assign pslverr     = st_r.pslverr;
    assign chan_clk_en = st_r.en;
    assign ext_line    = st_r.xl;

    property p_mode_write;
        @(posedge clock) disable iff (reset)
        (psel && !penable && pwrite && paddr == tccs_pkg::ADDR_BLOCK_MODE)
            |=> st_r.mode == $past(pwdata[5:0]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost"); // RL14

    property p_ro_write;
        @(posedge clock) disable iff (reset)
        (psel && !penable && pwrite && (paddr == tccs_pkg::ADDR_BUILD_PARAM
            || paddr == tccs_pkg::ADDR_MODULE_REV)) |=> $stable(st_r.mode) && $stable(st_r.chsel);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write changed state"); // RL15

    property p_rev_read;
        @(posedge clock) disable iff (reset)
        (psel && !penable && !pwrite && paddr == tccs_pkg::ADDR_MODULE_REV)
            |=> pready && prdata[11:0] == REVISION && prdata[31:20] == 12'h000;
    endproperty
    a_rev_read: assert property (p_rev_read) else $error("revision read wrong"); // RL7

    property p_build_read;
        @(posedge clock) disable iff (reset)
        (psel && !penable && !pwrite && paddr == tccs_pkg::ADDR_BUILD_PARAM)
            |=> prdata[7:0] == COUNTER_WIDTH && prdata[9] == BRIDGE_IS_PB_HSB
                && prdata[8] == UPDOWN_PRESENT;
    endproperty
    a_build_read: assert property (p_build_read) else $error("build read wrong"); // RL4 RL5 RL6

    property p_line0;
        @(posedge clock) disable iff (reset)
        (st_r.mode[1:0] == 2'h2) |=> st_r.xl[0] == $past(wave_out_a[1]);
    endproperty
    a_line0: assert property (p_line0) else $error("line 0 route wrong"); // RL1

    property p_line1_none;
        @(posedge clock) disable iff (reset)
        (st_r.mode[3:2] == 2'h1) |=> !st_r.xl[1];
    endproperty
    a_line1_none: assert property (p_line1_none) else $error("line 1 not idle"); // RL2

    property p_line2;
        @(posedge clock) disable iff (reset)
        (st_r.mode[5:4] == 2'h3) |=> st_r.xl[2] == $past(wave_out_a[1]);
    endproperty
    a_line2: assert property (p_line2) else $error("line 2 route wrong"); // RL3

    property p_div2;
        @(posedge clock) disable iff (reset)
        (st_r.chsel[2:0] == 3'h1 && $stable(st_r.chsel)) ##1 chan_clk_en[0]
            |=> !chan_clk_en[0] || st_r.chsel[2:0] != 3'h1;
    endproperty
    a_div2: assert property (p_div2) else $error("div2 enable too dense"); // RL11

    property p_slow;
        @(posedge clock) disable iff (reset)
        (st_r.chsel[5:3] == 3'h0 && $rose(st_r.osc_s)) |=> chan_clk_en[1];
    endproperty
    a_slow: assert property (p_slow) else $error("slow clock enable missed"); // RL10 RL9

    c_mode: cover property (@(posedge clock) disable iff (reset) st_r.mode == 6'h3f);
    c_en0:  cover property (@(posedge clock) disable iff (reset) chan_clk_en[0]);
    c_err:  cover property (@(posedge clock) disable iff (reset) pslverr);
endmodule

/* File: design/tccs_xroute.sv */
// external clock line router
`timescale 1ns/10ps
module tccs_xroute (
    tccs_sel_if.route bus   // selectors in, routed lines out
);
    // one table covers all three lines: the two waves are the other channels in order
    function automatic logic pick(input logic [1:0] code, input logic p,
                                  input logic lo, input logic hi);
        case (code)
            tccs_pkg::XSEL_PIN:     pick = p;
            tccs_pkg::XSEL_NONE:    pick = 1'b0;
            tccs_pkg::XSEL_WAVE_LO: pick = lo;
            default:                pick = hi;
        endcase
    endfunction
    assign bus.line[0] = pick(bus.sel[0], bus.pin[0], bus.wave[1], bus.wave[2]); // RL1
    assign bus.line[1] = pick(bus.sel[1], bus.pin[1], bus.wave[0], bus.wave[2]); // RL2
    assign bus.line[2] = pick(bus.sel[2], bus.pin[2], bus.wave[0], bus.wave[1]); // RL3
endmodule

/* File: dv/test_timer_clock_source_select.sv */
// self-checking testbench for the timer clock source selection block
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end
module test_timer_clock_source_select;
    logic        clock;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        slow_osc_clk;
    logic [2:0]  ext_pin;
    logic [2:0]  wave_out_a;
    logic [2:0]  chan_clk_en;
    logic [2:0]  ext_line;
    int          errors = 0;
    int          n_compared = 0;
    logic [31:0] rdat;
    logic        rerr;
    logic [2:0]  exl;

    // build options differ from defaults so a hard-wired value shows up
    tccs_top #(.BRIDGE_IS_PB_HSB(1'b1), .UPDOWN_PRESENT(1'b0), .COUNTER_WIDTH(8'h20),
        .REVISION(12'habc), .VARIANT(4'h5)) dut (
        .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slow_osc_clk(slow_osc_clk), .ext_pin(ext_pin),
        .wave_out_a(wave_out_a), .chan_clk_en(chan_clk_en), .ext_line(ext_line));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // waits for pready as long as it takes; only the watchdog ends a hung transfer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        `CHK("read data", e, rdat)
        `CHK("read error", ee, rerr)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        apb(1'b1, a, d);
        `CHK("write error", ee, rerr)
    endtask

    // window of 256 cycles is a multiple of every prescaler period, so counts are exact
    task automatic cnt(input int e0, input int e1, input int e2);
        int c0;
        int c1;
        int c2;
        c0 = 0;
        c1 = 0;
        c2 = 0;
        ext_pin <= 3'h0;
        slow_osc_clk <= 1'b0;
        repeat (8) @(posedge clock);
        for (int i = 0; i < 256; i++) begin
            @(posedge clock);
            c0 += chan_clk_en[0];
            c1 += chan_clk_en[1];
            c2 += chan_clk_en[2];
            ext_pin <= {2'h0, i[3]};
            slow_osc_clk <= i[4];
        end
        `CHK("chan0 pulses", e0, c0)
        `CHK("chan1 pulses", e1, c1)
        `CHK("chan2 pulses", e2, c2)
    endtask

    function automatic logic [2:0] route(input logic [1:0] c, input logic [2:0] p,
                                         input logic [2:0] w);
        case (c)
            2'h0: route = p;
            2'h1: route = 3'h0;
            2'h2: route = {w[0], w[0], w[1]};
            default: route = {w[1], w[2], w[2]};
        endcase
    endfunction

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #(40 * 6000);
        errors++;
        wrap_up();
    end

    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        slow_osc_clk = 1'b0;
        ext_pin = 3'h0;
        wave_out_a = 3'h0;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        rd(tccs_pkg::ADDR_BLOCK_MODE, 32'h0, 1'b0);
        rd(tccs_pkg::ADDR_CHAN_CLKSEL, 32'h0, 1'b0);
        $display("done: reset values");
        for (int k = 0; k < 2; k++) begin
            rd(tccs_pkg::ADDR_BUILD_PARAM, 32'h0000_0220, 1'b0);
            rd(tccs_pkg::ADDR_MODULE_REV, 32'h0005_0abc, 1'b0);
            wr(tccs_pkg::ADDR_BUILD_PARAM, 32'hffff_ffff, 1'b0);
            wr(tccs_pkg::ADDR_MODULE_REV, 32'h0000_0000, 1'b0);
        end
        rd(8'h40, 32'h0, 1'b1);
        wr(8'h40, 32'hffff_ffff, 1'b1);
        rd(tccs_pkg::ADDR_BLOCK_MODE, 32'h0, 1'b0);
        wr(tccs_pkg::ADDR_BLOCK_MODE, 32'hffff_ffff, 1'b0);
        rd(tccs_pkg::ADDR_BLOCK_MODE, 32'h0000_003f, 1'b0);
        $display("done: identification and access");
        for (int c = 0; c < 4; c++) begin
            wr(tccs_pkg::ADDR_BLOCK_MODE, {26'h0, c[1:0], c[1:0], c[1:0]}, 1'b0);
            for (int k = 0; k < 2; k++) begin
                ext_pin <= k[0] ? 3'h2 : 3'h5;
                wave_out_a <= k[0] ? 3'h6 : 3'h1;
                repeat (6) @(posedge clock);
                exl = route(c[1:0], k[0] ? 3'h2 : 3'h5, k[0] ? 3'h6 : 3'h1);
                `CHK("ext lines", exl, ext_line)
            end
        end
        wave_out_a <= 3'h0;
        $display("done: external line routing");
        wr(tccs_pkg::ADDR_BLOCK_MODE, 32'h0, 1'b0);
        wr(tccs_pkg::ADDR_CHAN_CLKSEL, 32'h0000_00d1, 1'b0);
        cnt(128, 32, 8);
        wr(tccs_pkg::ADDR_CHAN_CLKSEL, 32'h0000_002c, 1'b0);
        cnt(2, 16, 8);
        rd(tccs_pkg::ADDR_CHAN_CLKSEL, 32'h0000_002c, 1'b0);
        $display("done: channel clock choices");
        wrap_up();
    end
endmodule
